// [verilog/mcu_interrupt_unit.sv]
`timescale 1ns/1ps
`include "mcu_irq_params.svh"
module mcu_interrupt_unit #(
  parameter int IOC_PINS = 6,
  parameter int ADDR_W   = 8
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire mcu_irq_pkg::irq_events_t    events,
  input  wire logic                        ext_pin,
  input  wire logic [IOC_PINS-1:0]         pin_change_events,
  input  wire mcu_irq_pkg::core_ctx_t      core_ctx,
  input  wire logic                        return_from_handler_op,
  input  wire logic                        core_sleep,
  output logic                             vector_take,
  output logic [14:0]                      vector_pc,
  output logic                             ctx_restore,
  output mcu_irq_pkg::core_ctx_t           restore_ctx,
  output logic                             wake
);
  import mcu_irq_pkg::*;

  localparam int LAT_TAKE_MAX = 4;

  if (IOC_PINS < 1 || IOC_PINS > 8) begin : g_chk_pins
    $error("IOC_PINS must be 1 to 8");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must be 8 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                aw_have_reg,  aw_have_next;
  logic [7:0]          awaddr_reg,   awaddr_next;
  logic                w_have_reg,   w_have_next;
  logic [7:0]          wdata_reg,    wdata_next;
  logic                wstrb0_reg,   wstrb0_next;
  logic                awready_reg,  awready_next;
  logic                wready_reg,   wready_next;
  logic                bvalid_reg,   bvalid_next;
  logic [1:0]          bresp_reg,    bresp_next;
  logic                arready_reg,  arready_next;
  logic                rvalid_reg,   rvalid_next;
  logic [1:0]          rresp_reg,    rresp_next;
  logic [7:0]          rdata_reg,    rdata_next;
  logic [7:0]          ctrl_reg,     ctrl_next;
  logic [7:0]          option_reg,   option_next;
  logic [7:0]          pie_a_reg,    pie_a_next;
  logic [7:0]          pie_b_reg,    pie_b_next;
  core_ctx_t           shadow_reg,   shadow_next;
  core_ctx_t           restore_reg,  restore_next;
  logic                restore_p_reg, restore_p_next;
  logic                entry_reg,    entry_next;
  logic                wake_reg,     wake_next;
  logic [14:0]         vpc_reg;
  logic [1:0]          q_reg,        q_next;
  logic                hold_reg,     hold_next;
  unit_state_t         state_reg,    state_next;
  logic                ext_prev_reg, ext_armed_reg;

  logic [7:0]          core_flags;
  logic [7:0]          pir_a;
  logic [7:0]          pir_b;
  logic [IOC_PINS-1:0] pch_flags;
  logic                wr_fire, wr_hit, rd_hit;
  logic                we_ctrl, we_pir_a, we_pir_b, we_pch;
  logic [7:0]          rd_val;
  logic                ext_edge, pch_any, q1, req_pre, req_any, take;

  ////////////////////////////////////////////////////////////////////////////
  // Flags
  always_comb begin
    we_ctrl  = wr_fire && awaddr_reg == `OFS_INT_CTRL;
    we_pir_a = wr_fire && awaddr_reg == `OFS_PIR_A;
    we_pir_b = wr_fire && awaddr_reg == `OFS_PIR_B;
    we_pch   = wr_fire && awaddr_reg == `OFS_PIN_CHG;
  end

  always_comb begin
    if (option_reg[`BIT_EDGE_SEL]) begin
      ext_edge = ext_armed_reg && ext_pin && !ext_prev_reg;
    end else begin
      ext_edge = ext_armed_reg && !ext_pin && ext_prev_reg;
    end
  end

  irq_flag_cell #(.WIDTH(8), .MASK(`MASK_CORE_FLAGS)) u_core_flags (
    .clk       (clk),
    .rst_b     (rst_b),
    .set       ({5'h00, events.timer_ovf, ext_edge, 1'b0}),
    .wr_en     (we_ctrl),
    .wdata     (wdata_reg),
    .flags_reg (core_flags)
  );

  irq_flag_cell #(.WIDTH(8), .MASK(`MASK_PIR_A)) u_pir_a (
    .clk       (clk),
    .rst_b     (rst_b),
    .set       ({1'b0, events.converter_done, 2'h0, events.serial_port, 3'h0}),
    .wr_en     (we_pir_a),
    .wdata     (wdata_reg),
    .flags_reg (pir_a)
  );

  irq_flag_cell #(.WIDTH(8), .MASK(`MASK_PIR_B)) u_pir_b (
    .clk       (clk),
    .rst_b     (rst_b),
    .set       ({4'h0, events.bus_collision, 3'h0}),
    .wr_en     (we_pir_b),
    .wdata     (wdata_reg),
    .flags_reg (pir_b)
  );

  irq_flag_cell #(.WIDTH(IOC_PINS), .MASK({IOC_PINS{1'b1}})) u_pin_change (
    .clk       (clk),
    .rst_b     (rst_b),
    .set       (pin_change_events),
    .wr_en     (we_pch),
    .wdata     (wdata_reg[IOC_PINS-1:0]),
    .flags_reg (pch_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request combine
  always_comb begin
    pch_any = |pch_flags;
    req_pre = (core_flags[`BIT_TMR_FLAG] && ctrl_reg[`BIT_TMR_IE])
           || (core_flags[`BIT_EXT_FLAG] && ctrl_reg[`BIT_EXT_IE])
           || (pch_any && ctrl_reg[`BIT_PCH_IE])
           || (ctrl_reg[`BIT_PERIPH_GROUP_ENABLE] && (|(pir_a & pie_a_reg) || |(pir_b & pie_b_reg)));
    req_any = req_pre && ctrl_reg[`BIT_GIE];
    q1      = q_reg == `Q1_PHASE;
    take    = state_reg == ST_RUN && q1 && req_any && !return_from_handler_op;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next     = state_reg;
    hold_next      = hold_reg;
    wake_next      = 1'b0;
    entry_next     = take;
    restore_p_next = return_from_handler_op;
    restore_next   = restore_reg;
    shadow_next    = shadow_reg;
    ctrl_next      = ctrl_reg;
    q_next         = q_reg + 2'h1;
    unique case (state_reg)
      ST_RUN: begin
        if (core_sleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (req_pre) begin
          wake_next  = 1'b1;
          hold_next  = 1'b0;
          state_next = ST_WAKE_HOLD;
        end
      end
      ST_WAKE_HOLD: begin
        if (q1) begin
          hold_next = 1'b1;
          if (hold_reg) begin
            state_next = ST_RUN;
          end
        end
      end
    endcase
    if (we_ctrl) begin
      ctrl_next = wdata_reg & `MASK_CTRL_EN;
    end
    if (wr_fire) begin
      unique case (awaddr_reg)
        `OFS_SH_W:      shadow_next.w             = wdata_reg;
        `OFS_SH_STATUS: shadow_next.status        = wdata_reg & `MASK_STATUS_SAVE;
        `OFS_SH_BSR:    shadow_next.bank_select_reg           = wdata_reg[4:0];
        `OFS_SH_FSR0L:  shadow_next.fsr0[7:0]     = wdata_reg;
        `OFS_SH_FSR0H:  shadow_next.fsr0[15:8]    = wdata_reg;
        `OFS_SH_FSR1L:  shadow_next.fsr1[7:0]     = wdata_reg;
        `OFS_SH_FSR1H:  shadow_next.fsr1[15:8]    = wdata_reg;
        `OFS_SH_PC_HIGH_LATCH: shadow_next.pc_high_latch = wdata_reg[6:0];
        default: ;
      endcase
    end
    if (return_from_handler_op) begin
      ctrl_next[`BIT_GIE] = 1'b1;
      restore_next        = shadow_reg;
    end
    if (take) begin
      ctrl_next[`BIT_GIE] = 1'b0;
      shadow_next         = core_ctx;
      shadow_next.status  = core_ctx.status & `MASK_STATUS_SAVE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg     <= ST_RUN;
      hold_reg      <= 1'b0;
      wake_reg      <= 1'b0;
      entry_reg     <= 1'b0;
      restore_p_reg <= 1'b0;
      restore_reg   <= '0;
      shadow_reg    <= '0;
      ctrl_reg      <= `RST_CTRL;
      q_reg         <= `Q1_PHASE;
      vpc_reg       <= `VECTOR_ADDR;
      ext_prev_reg  <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      hold_reg      <= hold_next;
      wake_reg      <= wake_next;
      entry_reg     <= entry_next;
      restore_p_reg <= restore_p_next;
      restore_reg   <= restore_next;
      shadow_reg    <= shadow_next;
      ctrl_reg      <= ctrl_next;
      q_reg         <= q_next;
      vpc_reg       <= `VECTOR_ADDR;
      ext_prev_reg  <= ext_pin;
      ext_armed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read in flight
  always_comb begin
    unique case (s_axi_araddr[7:0])
      `OFS_INT_CTRL:    rd_val = {ctrl_reg[7:3], core_flags[2:1], pch_any};
      `OFS_OPTION:      rd_val = option_reg;
      `OFS_PIE_A:       rd_val = pie_a_reg;
      `OFS_PIE_B:       rd_val = pie_b_reg;
      `OFS_PIR_A:       rd_val = pir_a;
      `OFS_PIR_B:       rd_val = pir_b;
      `OFS_PIN_CHG:     rd_val = 8'(pch_flags);
      `OFS_UNIT_STATUS: rd_val = {4'h0, req_pre, 1'b0, state_reg};
      `OFS_SH_W:        rd_val = shadow_reg.w;
      `OFS_SH_STATUS:   rd_val = shadow_reg.status;
      `OFS_SH_BSR:      rd_val = {3'h0, shadow_reg.bank_select_reg};
      `OFS_SH_FSR0L:    rd_val = shadow_reg.fsr0[7:0];
      `OFS_SH_FSR0H:    rd_val = shadow_reg.fsr0[15:8];
      `OFS_SH_FSR1L:    rd_val = shadow_reg.fsr1[7:0];
      `OFS_SH_FSR1H:    rd_val = shadow_reg.fsr1[15:8];
      `OFS_SH_PC_HIGH_LATCH:   rd_val = {1'b0, shadow_reg.pc_high_latch};
      default:          rd_val = 8'h00;
    endcase
    rd_hit = (s_axi_araddr >> 8) == '0 && s_axi_araddr[1:0] == 2'h0
          && (s_axi_araddr[7:0] <= `OFS_UNIT_STATUS
          || (s_axi_araddr[7:0] >= `OFS_SH_W && s_axi_araddr[7:0] <= `OFS_SH_PC_HIGH_LATCH));
    wr_hit = awaddr_reg[1:0] == 2'h0 && awaddr_reg != `OFS_UNIT_STATUS
          && (awaddr_reg < `OFS_UNIT_STATUS
          || (awaddr_reg >= `OFS_SH_W && awaddr_reg <= `OFS_SH_PC_HIGH_LATCH));
  end

  // Address bits above the byte offset are checked when the address is taken
  logic aw_high_ok_reg, aw_high_ok_next;

  always_comb begin
    aw_have_next    = aw_have_reg;
    awaddr_next     = awaddr_reg;
    aw_high_ok_next = aw_high_ok_reg;
    w_have_next     = w_have_reg;
    wdata_next      = wdata_reg;
    wstrb0_next     = wstrb0_reg;
    bvalid_next     = bvalid_reg;
    bresp_next      = bresp_reg;
    rvalid_next     = rvalid_reg;
    rresp_next      = rresp_reg;
    rdata_next      = rdata_reg;
    option_next     = option_reg;
    pie_a_next      = pie_a_reg;
    pie_b_next      = pie_b_reg;
    wr_fire         = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next    = 1'b1;
      awaddr_next     = s_axi_awaddr[7:0];
      aw_high_ok_next = (s_axi_awaddr >> 8) == '0;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      wr_fire      = wr_hit && aw_high_ok_reg && wstrb0_reg;
      bvalid_next  = 1'b1;
      bresp_next   = (wr_hit && aw_high_ok_reg) ? `AXI_OKAY : `AXI_SLVERR;
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
    end
    if (wr_fire && awaddr_reg == `OFS_OPTION) begin
      option_next = wdata_reg & (8'h01 << `BIT_EDGE_SEL);
    end
    if (wr_fire && awaddr_reg == `OFS_PIE_A) begin
      pie_a_next = wdata_reg & `MASK_PIR_A;
    end
    if (wr_fire && awaddr_reg == `OFS_PIE_B) begin
      pie_b_next = wdata_reg & `MASK_PIR_B;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_hit ? rd_val : 8'h00;
      rresp_next  = rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_have_reg    <= 1'b0;
      awaddr_reg     <= 8'h00;
      aw_high_ok_reg <= 1'b0;
      w_have_reg     <= 1'b0;
      wdata_reg      <= 8'h00;
      wstrb0_reg     <= 1'b0;
      awready_reg    <= 1'b0;
      wready_reg     <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= `AXI_OKAY;
      arready_reg    <= 1'b0;
      rvalid_reg     <= 1'b0;
      rresp_reg      <= `AXI_OKAY;
      rdata_reg      <= 8'h00;
      option_reg     <= `RST_OPTION;
      pie_a_reg      <= `RST_PIE;
      pie_b_reg      <= `RST_PIE;
    end else begin
      aw_have_reg    <= aw_have_next;
      awaddr_reg     <= awaddr_next;
      aw_high_ok_reg <= aw_high_ok_next;
      w_have_reg     <= w_have_next;
      wdata_reg      <= wdata_next;
      wstrb0_reg     <= wstrb0_next;
      awready_reg    <= awready_next;
      wready_reg     <= wready_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      arready_reg    <= arready_next;
      rvalid_reg     <= rvalid_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
      option_reg     <= option_next;
      pie_a_reg      <= pie_a_next;
      pie_b_reg      <= pie_b_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign vector_take   = entry_reg;
  assign vector_pc     = vpc_reg;
  assign ctx_restore   = restore_p_reg;
  assign restore_ctx   = restore_reg;
  assign wake          = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_taken;
    ##[1:LAT_TAKE_MAX] entry_reg;
  endsequence

  property p_reset_quiet;
    @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !ctrl_reg[`BIT_GIE] && !entry_reg;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("enabled after reset");

  property p_entry_cause;
    @(posedge clk) disable iff (!rst_b)
      entry_reg |-> $past(req_any) && $past(q1) && !ctrl_reg[`BIT_GIE] && vpc_reg == 15'h0004;
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("entry without cause");

  property p_flag_sets;
    @(posedge clk) disable iff (!rst_b) events.timer_ovf |=> core_flags[`BIT_TMR_FLAG];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("timer flag not set");

  property p_gie_off_quiet;
    @(posedge clk) disable iff (!rst_b) !ctrl_reg[`BIT_GIE] |=> !entry_reg;
  endproperty
  a_gie_off_quiet: assert property (p_gie_off_quiet) else $error("entry with gie off");

  property p_return;
    @(posedge clk) disable iff (!rst_b)
      return_from_handler_op |=> ctx_restore && ctrl_reg[`BIT_GIE]
                                 && restore_ctx == $past(shadow_reg);
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong");

  property p_latency;
    @(posedge clk) disable iff (!rst_b)
      (req_any && state_reg == ST_RUN && q1 && !return_from_handler_op)
        |-> s_taken;
  endproperty
  a_latency: assert property (p_latency) else $error("entry too late");

  property p_wake_hold;
    @(posedge clk) disable iff (!rst_b) wake_reg |-> !entry_reg [*4];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("entry before next instr");

  property p_ext_edge;
    @(posedge clk) disable iff (!rst_b)
      (ext_armed_reg && option_reg[`BIT_EDGE_SEL] && ext_pin && !ext_prev_reg)
        |=> core_flags[`BIT_EXT_FLAG];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("rising edge missed");

  property p_pch_read;
    @(posedge clk) disable iff (!rst_b)
      (s_axi_arvalid && arready_reg && s_axi_araddr == '0)
        |=> rdata_reg[`BIT_PCH_FLAG] == $past(|pch_flags);
  endproperty
  a_pch_read: assert property (p_pch_read) else $error("pin change summary wrong");

  property p_group_gate;
    @(posedge clk) disable iff (!rst_b)
      (!ctrl_reg[`BIT_PERIPH_GROUP_ENABLE] && !ctrl_reg[`BIT_TMR_IE] && !ctrl_reg[`BIT_EXT_IE]
       && !ctrl_reg[`BIT_PCH_IE]) |-> !req_pre;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("ungated request");

endmodule

// [pkg/mcu_irq_params.svh]
`ifndef MCU_IRQ_PARAMS_SVH
`define MCU_IRQ_PARAMS_SVH

// Register byte offsets
`define OFS_INT_CTRL      8'h00
`define OFS_OPTION        8'h04
`define OFS_PIE_A         8'h08
`define OFS_PIE_B         8'h0c
`define OFS_PIR_A         8'h10
`define OFS_PIR_B         8'h14
`define OFS_PIN_CHG       8'h18
`define OFS_UNIT_STATUS   8'h1c
`define OFS_SH_W          8'h40
`define OFS_SH_STATUS     8'h44
`define OFS_SH_BSR        8'h48
`define OFS_SH_FSR0L      8'h4c
`define OFS_SH_FSR0H      8'h50
`define OFS_SH_FSR1L      8'h54
`define OFS_SH_FSR1H      8'h58
`define OFS_SH_PC_HIGH_LATCH     8'h5c

// Field positions in interrupt_control, option and the peripheral flag registers
`define BIT_GIE           7
`define BIT_PERIPH_GROUP_ENABLE          6
`define BIT_TMR_IE        5
`define BIT_EXT_IE        4
`define BIT_PCH_IE        3
`define BIT_TMR_FLAG      2
`define BIT_EXT_FLAG      1
`define BIT_PCH_FLAG      0
`define BIT_EDGE_SEL      6
`define BIT_CONV          6
`define BIT_SERIAL        3
`define BIT_BUS_COLL      3

// Implemented-bit masks and reset values
`define MASK_CTRL_EN      8'hf8
`define MASK_CORE_FLAGS   8'h06
`define MASK_PIR_A        8'h48
`define MASK_PIR_B        8'h08
`define MASK_STATUS_SAVE  8'h07
`define RST_CTRL          8'h00
`define RST_OPTION        8'h00
`define RST_PIE           8'h00

// Vector, timing and AXI response codes
`define VECTOR_ADDR       15'h0004
`define Q1_PHASE          2'h0
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// [pkg/mcu_irq_pkg.sv]
package mcu_irq_pkg;

  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [4:0]  bank_select_reg;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [6:0]  pc_high_latch;
  } core_ctx_t;

  typedef struct packed {
    logic timer_ovf;
    logic converter_done;
    logic serial_port;
    logic bus_collision;
  } irq_events_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_HOLD
  } unit_state_t;

endpackage

// [verilog/irq_flag_cell.sv]
`timescale 1ns/1ps
module irq_flag_cell #(
  parameter int         WIDTH = 8,
  parameter [WIDTH-1:0] MASK  = '1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] flags_reg
);

  logic [WIDTH-1:0] flags_next;

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    flags_next = wr_en ? wdata : flags_reg;
    flags_next = (flags_next | set) & MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule

// [testbench/core_model.sv]
`timescale 1ns/1ps
module core_model (
  input  wire logic              clk,
  input  wire logic              vector_take,
  output mcu_irq_pkg::core_ctx_t core_ctx,
  output logic                   return_from_handler_op = 1'b0
);
  import mcu_irq_pkg::*;
  int cnt = 0;
  ////////////////////////////////////////////////////////////////
  // handler runs then returns
  // Long handler so the bench can clear flags before the return
  always @(posedge clk) begin
    return_from_handler_op <= (cnt == 1);
    cnt <= vector_take ? 40 : (cnt > 0 ? cnt - 1 : 0);
  end
  assign core_ctx = '{w: 8'h3c, status: 8'h1f, bank_select_reg: 5'h1f, fsr0: 16'h1234,
                      fsr1: 16'h5678, pc_high_latch: 7'h55};
endmodule

// [testbench/mcu_interrupt_unit_tb.sv]
`timescale 1ns/1ps
module mcu_interrupt_unit_tb;
  import mcu_irq_pkg::*;
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
  logic        clk = 1'b0, rst_b = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  irq_events_t events = '0;
  core_ctx_t   core_ctx, restore_ctx;
  logic        return_from_handler_op, vector_take, ctx_restore, wake;
  logic [14:0] vector_pc;
  logic        ext_pin = 1'b0, core_sleep = 1'b0;
  logic [5:0]  pin_change_events = 6'h00;
  int          miscompares = 0, check_count = 0, takes = 0, lat;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (vector_take === 1'b1) takes++;
  mcu_interrupt_unit dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .ext_pin,
    .pin_change_events, .core_ctx, .return_from_handler_op, .core_sleep,
    .vector_take, .vector_pc, .ctx_restore, .restore_ctx, .wake);
  core_model core (.clk, .vector_take, .core_ctx, .return_from_handler_op);
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_timer();
    events.timer_ovf <= 1'b1;
    @(posedge clk);
    events.timer_ovf <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdr(8'h00); `CHK("ctrl", 8'h00, rd)
    `CHK("vec", 15'h0004, vector_pc)
    rdr(8'h20); `CHK("unmapped", 2'h2, rs)
    $display("test reset done");
  endtask
  task automatic t_masked();
    pulse_timer();
    repeat (12) @(posedge clk);
    rdr(8'h00); `CHK("flag", 8'h04, rd)
    `CHK("takes", 0, takes)
    wr(8'h00, 8'h00);
    $display("test masked done");
  endtask
  task automatic t_entry();
    wr(8'h00, 8'ha0);
    pulse_timer();
    lat = 0;
    while (vector_take !== 1'b1 && lat < 20) begin @(posedge clk); lat++; end
    `CHK("latency", 1'b1, lat >= 1 && lat <= 6)
    `CHK("vec", 15'h0004, vector_pc)
    rdr(8'h00); `CHK("ctrl", 8'h24, rd)
    wr(8'h40, 8'h99);
    wr(8'h00, 8'h20);
    while (ctx_restore !== 1'b1) @(posedge clk);
    `CHK("sh_w", 8'h99, restore_ctx.w)
    `CHK("sh_st", 8'h07, restore_ctx.status)
    `CHK("sh_fsr1", 16'h5678, restore_ctx.fsr1)
    rdr(8'h00); `CHK("ctrl", 8'ha0, rd)
    `CHK("takes", 1, takes)
    $display("test entry done");
  endtask
  task automatic t_sources();
    wr(8'h04, 8'h40);
    ext_pin <= 1'b1;
    pin_change_events <= 6'h01;
    @(posedge clk);
    pin_change_events <= 6'h00;
    repeat (2) @(posedge clk);
    rdr(8'h00); `CHK("edge", 8'ha3, rd)
    rdr(8'h18); `CHK("pch", 8'h01, rd)
    wr(8'h00, 8'h01);
    ext_pin <= 1'b0;
    repeat (2) @(posedge clk);
    rdr(8'h00); `CHK("ro_bit", 8'h01, rd)
    wr(8'h18, 8'h00);
    rdr(8'h00); `CHK("pch_clr", 8'h00, rd)
    wr(8'h1c, 8'hff); `CHK("ro_wr", 2'h2, rs)
    wr(8'h08, 8'h40);
    wr(8'h00, 8'h80);
    events.converter_done <= 1'b1;
    @(posedge clk);
    events.converter_done <= 1'b0;
    repeat (6) @(posedge clk);
    rdr(8'h10); `CHK("pir", 8'h40, rd)
    rdr(8'h1c); `CHK("gated", 8'h00, rd)
    `CHK("takes", 1, takes)
    wr(8'h00, 8'hc0);
    lat = 0;
    while (takes < 2 && lat < 20) begin @(posedge clk); lat++; end
    wr(8'h10, 8'h00);
    while (ctx_restore !== 1'b1) @(posedge clk);
    `CHK("sh_w2", 8'h3c, restore_ctx.w)
    `CHK("sh_pcl", 7'h55, restore_ctx.pc_high_latch)
    `CHK("takes", 2, takes)
    wr(8'h00, 8'h00);
    $display("test sources done");
  endtask
  task automatic t_sleep();
    wr(8'h00, 8'h20);
    core_sleep <= 1'b1;
    @(posedge clk);
    pulse_timer();
    lat = 0;
    while (wake !== 1'b1 && lat < 20) begin @(posedge clk); lat++; end
    core_sleep <= 1'b0;
    `CHK("wake", 1'b1, lat < 20)
    repeat (12) @(posedge clk);
    `CHK("takes", 2, takes)
    wr(8'h00, 8'h00);
    wr(8'h00, 8'hf8);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdr(8'h00); `CHK("rst2", 8'h00, rd)
    $display("test sleep done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin #100us; miscompares++; report_and_stop(); end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_masked();
    t_entry();
    t_sources();
    t_sleep();
    report_and_stop();
  end
endmodule
